// >>> src/psr_defs.svh
// offsets, field positions, reset values and timing counts of the clock
`ifndef PSR_DEFS_SVH
`define PSR_DEFS_SVH
`define PSR_UNLOCK_PATTERN 64'h5ca33ac55ca33ac5
`define PSR_XFER_BITS      64
`define PSR_LAST_BIT       6'h3f
`define PSR_ZERO_MASK      64'hff1f3f37bf7f7fff
`define PSR_RST_REGS       64'h0001012100000000
`define PSR_IDX_FRAC       0
`define PSR_IDX_SEC        1
`define PSR_IDX_MIN        2
`define PSR_IDX_HOUR       3
`define PSR_IDX_WDAY       4
`define PSR_IDX_DATE       5
`define PSR_IDX_MON        6
`define PSR_IDX_YEAR       7
`define PSR_HR_FMT         7
`define PSR_HR_PM          5
`define PSR_WD_RSTIGN      4
`define PSR_WD_HALT        5
`define PSR_CLK_NS         5
`define PSR_HUNDREDTH_NS   10000000
`endif

// >>> src/psr_pkg.sv
// types of the phantom clock access logic
package psr_pkg;
	typedef enum logic [0:0]
	{
		PSR_HUNT = 1'b0,
		PSR_XFER = 1'b1
	} psr_mode_e;
endpackage

// >>> src/psr_rtc_core.sv
// serial access, unlock and timekeeping registers of the phantom clock
// Notes on behaviour
// - unlock bytes c5 3a a3 5c twice, lsb first
// - eight byte registers, serial after 64-bit unlock
// - transfer walks reg0 bit0 to reg7 bit7
// - all time fields are bcd digits
// - hours bit 7 high selects 12-hour
// - hours bit 5 is pm or tens
// - day bit 4 set ignores reset pin
// - reset pin acts regardless of strobes
// - day bit 5 low runs the counters
// - unused bits read zero, writes ignored
// - hours layout, range 01-12 or 00-23
// - date field two-bit tens, range 01-31
// - read during unlock restarts the compare
// - mismatch freezes pointer until a read
// - 64 data cycles, memory select held high
// - before unlock, accesses pass to memory
`timescale 1ns/100ps
`include "psr_defs.svh"
module psr_rtc_core
	import psr_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `PSR_HUNDREDTH_NS / `PSR_CLK_NS
)
(
	input  wire logic clk_sys_i,
	input  wire logic rst_b_i,
	input  wire logic chip_select_in_b_i,
	input  wire logic oe_b_i,
	input  wire logic we_b_i,
	input  wire logic data_in_i,
	input  wire logic reset_pin_b_i,
	output logic      memory_select_out_b_o,
	output logic      data_out_o,
	output logic      data_out_oe_o
);
	localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
	localparam logic [63:0] UNLOCK_PAT = `PSR_UNLOCK_PATTERN;

	function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
		input logic [7:0] hi);
		if (v >= hi)
			return {1'b1, lo};
		if (v[3:0] == 4'h9)
			return {1'b0, v[7:4] + 4'h1, 4'h0};
		return {1'b0, v[7:4], v[3:0] + 4'h1};
	endfunction

	function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		if (mon == 8'h02)
			return leap ? 8'h29 : 8'h28;
		if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11)
			return 8'h30;
		return 8'h31;
	endfunction

	psr_mode_e     mode_ff, nxt_mode;
	logic [5:0]    ptr_ff, nxt_ptr;
	logic          fail_ff, nxt_fail;
	logic [5:0]    cnt_ff, nxt_cnt;
	logic [63:0]   shadow_ff, nxt_shadow;
	logic          dirty_ff, nxt_dirty;
	logic          act_ff;
	logic          wr_ff, nxt_wr;
	logic          wbit_ff, nxt_wbit;
	logic          mem_b_ff, nxt_mem_b;
	logic          q_ff, nxt_q;
	logic          q_oe_ff, nxt_q_oe;
	logic          commit, act, start, done, abort, halt;
	logic [63:0]   regs_ff, nxt_regs;
	logic [TW-1:0] tick_ff, nxt_tick;

	assign act   = !chip_select_in_b_i && (!we_b_i || !oe_b_i);
	assign start = act && !act_ff;
	assign done  = !act && act_ff;
	// reset pin sampled whatever the strobes show
	assign abort = !reset_pin_b_i && !regs_ff[8*`PSR_IDX_WDAY + `PSR_WD_RSTIGN];
	assign halt  = regs_ff[8*`PSR_IDX_WDAY + `PSR_WD_HALT];

	// access sequencing
	always_comb
	begin
		nxt_mode   = mode_ff;
		nxt_ptr    = ptr_ff;
		nxt_fail   = fail_ff;
		nxt_cnt    = cnt_ff;
		nxt_shadow = shadow_ff;
		nxt_dirty  = dirty_ff;
		nxt_wr     = start ? !we_b_i : wr_ff;
		nxt_wbit   = act ? data_in_i : wbit_ff;
		nxt_q      = q_ff;
		nxt_q_oe   = q_oe_ff && act;
		commit     = 1'b0;
		if (mode_ff == PSR_HUNT && done)
		begin
			if (!wr_ff)
			begin
				nxt_ptr  = 6'h00;
				nxt_fail = 1'b0;
			end
			else if (!fail_ff)
			begin
				if (wbit_ff == UNLOCK_PAT[ptr_ff])
				begin
					nxt_ptr = ptr_ff + 6'h01;
					if (ptr_ff == `PSR_LAST_BIT)
					begin
						nxt_mode   = PSR_XFER;
						nxt_cnt    = 6'h00;
						nxt_shadow = regs_ff;
						nxt_dirty  = 1'b0;
					end
				end
				else
					nxt_fail = 1'b1;
			end
		end
		if (mode_ff == PSR_XFER)
		begin
			if (start && we_b_i)
			begin
				nxt_q    = shadow_ff[cnt_ff];
				nxt_q_oe = 1'b1;
			end
			if (done)
			begin
				if (wr_ff)
				begin
					nxt_shadow[cnt_ff] = wbit_ff;
					nxt_dirty          = 1'b1;
				end
				nxt_cnt = cnt_ff + 6'h01;
				if (cnt_ff == `PSR_LAST_BIT)
				begin
					nxt_mode = PSR_HUNT;
					nxt_ptr  = 6'h00;
					nxt_fail = 1'b0;
					commit   = dirty_ff || wr_ff;
				end
			end
		end
		if (abort)
		begin
			nxt_mode  = PSR_HUNT;
			nxt_ptr   = 6'h00;
			nxt_fail  = 1'b0;
			nxt_dirty = 1'b0;
			nxt_q_oe  = 1'b0;
			commit    = 1'b0;
		end
		nxt_mem_b = (mode_ff == PSR_XFER) ? 1'b1 : chip_select_in_b_i;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
		begin
			mode_ff   <= PSR_HUNT;
			ptr_ff    <= 6'h00;
			fail_ff   <= 1'b0;
			cnt_ff    <= 6'h00;
			shadow_ff <= 64'h0;
			dirty_ff  <= 1'b0;
			act_ff    <= 1'b0;
			wr_ff     <= 1'b0;
			wbit_ff   <= 1'b0;
			mem_b_ff  <= 1'b1;
			q_ff      <= 1'b0;
			q_oe_ff   <= 1'b0;
		end
		else
		begin
			mode_ff   <= nxt_mode;
			ptr_ff    <= nxt_ptr;
			fail_ff   <= nxt_fail;
			cnt_ff    <= nxt_cnt;
			shadow_ff <= nxt_shadow;
			dirty_ff  <= nxt_dirty;
			act_ff    <= act;
			wr_ff     <= nxt_wr;
			wbit_ff   <= nxt_wbit;
			mem_b_ff  <= nxt_mem_b;
			q_ff      <= nxt_q;
			q_oe_ff   <= nxt_q_oe;
		end
	end

	assign memory_select_out_b_o = mem_b_ff;
	assign data_out_o            = q_ff;
	assign data_out_oe_o         = q_oe_ff;

	// timekeeping cascade
	always_comb
	begin
		logic [8:0] s;
		logic [7:0] h;
		logic       c;
		s        = 9'h0;
		h        = 8'h0;
		c        = 1'b0;
		nxt_regs = regs_ff;
		nxt_tick = tick_ff;
		if (!halt)
		begin
			c        = (tick_ff == TW'(TICK_CYCLES - 1));
			nxt_tick = c ? '0 : tick_ff + TW'(1);
		end
		if (c)
		begin
			s = bcd_inc(regs_ff[7:0], 8'h00, 8'h99);
			nxt_regs[7:0] = s[7:0];
			c = s[8];
		end
		if (c)
		begin
			s = bcd_inc(regs_ff[15:8], 8'h00, 8'h59);
			nxt_regs[15:8] = s[7:0];
			c = s[8];
		end
		if (c)
		begin
			s = bcd_inc(regs_ff[23:16], 8'h00, 8'h59);
			nxt_regs[23:16] = s[7:0];
			c = s[8];
		end
		if (c)
		begin
			h = regs_ff[31:24];
			if (h[`PSR_HR_FMT])
			begin
				c = 1'b0;
				if ({3'b000, h[4:0]} == 8'h11)
				begin
					c = h[`PSR_HR_PM];
					h = {2'b10, !h[`PSR_HR_PM], 5'h12};
				end
				else if ({3'b000, h[4:0]} == 8'h12)
					h = {2'b10, h[`PSR_HR_PM], 5'h01};
				else
				begin
					s = bcd_inc({3'b000, h[4:0]}, 8'h01, 8'h12);
					h = {2'b10, h[`PSR_HR_PM], s[4:0]};
				end
			end
			else
			begin
				s = bcd_inc({2'b00, h[5:0]}, 8'h00, 8'h23);
				h = {2'b00, s[5:0]};
				c = s[8];
			end
			nxt_regs[31:24] = h;
		end
		if (c)
		begin
			s = bcd_inc({5'h00, regs_ff[34:32]}, 8'h01, 8'h07);
			nxt_regs[34:32] = s[2:0];
			s = bcd_inc(regs_ff[47:40], 8'h01, month_len(regs_ff[55:48], regs_ff[63:56]));
			nxt_regs[47:40] = s[7:0];
			c = s[8];
		end
		if (c)
		begin
			s = bcd_inc(regs_ff[55:48], 8'h01, 8'h12);
			nxt_regs[55:48] = s[7:0];
			c = s[8];
		end
		if (c)
		begin
			s = bcd_inc(regs_ff[63:56], 8'h00, 8'h99);
			nxt_regs[63:56] = s[7:0];
		end
		if (commit)
			nxt_regs = nxt_shadow & `PSR_ZERO_MASK;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
		begin
			regs_ff <= `PSR_RST_REGS;
			tick_ff <= '0;
		end
		else
		begin
			regs_ff <= nxt_regs;
			tick_ff <= nxt_tick;
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_unlock_step;
		mode_ff == PSR_HUNT ##1 mode_ff == PSR_XFER;
	endsequence
	sequence s_last_data;
		mode_ff == PSR_XFER && done && cnt_ff == `PSR_LAST_BIT && !abort;
	endsequence

	mem_hold_a: assert property (mode_ff == PSR_XFER |=> memory_select_out_b_o)
		else $error("memory select low during clock access");
	mem_pass_a: assert property (mode_ff == PSR_HUNT |=>
		memory_select_out_b_o == $past(chip_select_in_b_i))
		else $error("memory select not following chip select");
	read_restart_a: assert property (mode_ff == PSR_HUNT && done && !wr_ff |=>
		ptr_ff == 6'h00 && !fail_ff)
		else $error("read did not restart unlock");
	mismatch_freeze_a: assert property (mode_ff == PSR_HUNT && fail_ff && !abort &&
		!(done && !wr_ff) |=> $stable(ptr_ff) && fail_ff)
		else $error("pointer moved after mismatch");
	unlock_start_a: assert property (s_unlock_step |-> cnt_ff == 6'h00 &&
		$past(ptr_ff) == `PSR_LAST_BIT)
		else $error("clock access opened without full unlock");
	xfer_exit_a: assert property (s_last_data |=> mode_ff == PSR_HUNT ##1
		memory_select_out_b_o == $past(chip_select_in_b_i))
		else $error("clock access not closed after 64 cycles");
	pin_abort_a: assert property (abort |=> mode_ff == PSR_HUNT && ptr_ff == 6'h00 &&
		!data_out_oe_o)
		else $error("reset pin did not abort");
	pin_ignored_a: assert property (!reset_pin_b_i && mode_ff == PSR_XFER && !done &&
		regs_ff[8*`PSR_IDX_WDAY + `PSR_WD_RSTIGN] |=> mode_ff == PSR_XFER)
		else $error("reset pin acted while ignored");
	halt_freeze_a: assert property (halt && !commit |=> $stable(regs_ff))
		else $error("counters moved while halted");
	zero_bits_a: assert property ((regs_ff & ~`PSR_ZERO_MASK) == 64'h0)
		else $error("unused bit holds a one");
	read_bit_a: assert property (mode_ff == PSR_XFER && start && we_b_i && !abort |=>
		data_out_oe_o && data_out_o == $past(shadow_ff[cnt_ff]))
		else $error("wrong bit driven on read");
endmodule

// >>> tb/psr_host_model.sv
// host side model driving the phantom clock strobes
`timescale 1ns/100ps
`include "psr_defs.svh"
module psr_host_model
(
	input  wire logic clk_sys_i,
	input  wire logic dout_i,
	input  wire logic dout_oe_i,
	input  wire logic ms_b_i,
	output logic      cs_b_o,
	output logic      oe_b_o,
	output logic      we_b_o,
	output logic      din_o
);
	initial
	begin
		cs_b_o = 1'b1;
		oe_b_o = 1'b1;
		we_b_o = 1'b1;
		din_o = 1'b0;
	end
	// one strobe cycle, sampled just before release
	task automatic cyc(input logic w, input logic d, output logic q, output logic ms,
		output logic qe);
		@(negedge clk_sys_i);
		cs_b_o <= 1'b0;
		we_b_o <= !w;
		oe_b_o <= w;
		din_o <= d;
		repeat (3) @(negedge clk_sys_i);
		q = dout_i;
		ms = ms_b_i;
		qe = dout_oe_i;
		cs_b_o <= 1'b1;
		we_b_o <= 1'b1;
		oe_b_o <= 1'b1;
		din_o <= !d;
		repeat (2) @(negedge clk_sys_i);
	endtask
	// read restarts the compare, then n pattern writes, bit bad flipped
	task automatic unlock(input int n, input int bad);
		logic        q;
		logic        ms;
		logic        qe;
		logic [63:0] pat;
		pat = `PSR_UNLOCK_PATTERN;
		cyc(1'b0, 1'b0, q, ms, qe);
		for (int i = 0; i < n; i++)
			cyc(1'b1, pat[i] ^ (i == bad), q, ms, qe);
	endtask
	// full 64-bit walk, lsb of register 0 first
	task automatic xfer(input logic w, input logic [63:0] v, output logic [63:0] r,
		output logic ms_all, output logic qe_all);
		logic q;
		logic ms;
		logic qe;
		ms_all = 1'b1;
		qe_all = 1'b1;
		for (int i = 0; i < `PSR_XFER_BITS; i++)
		begin
			cyc(w, v[i], q, ms, qe);
			r[i] = q;
			ms_all &= ms;
			qe_all &= qe;
		end
	endtask
endmodule

// >>> tb/psr_rtc_core_tb.sv
// self-checking bench of the phantom clock access logic
`timescale 1ns/100ps
`include "psr_defs.svh"
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin bad_count++; \
	$display("MISMATCH %s exp %h got %h", n, e, s); end end
module psr_rtc_core_tb;
	logic        clk_sys;
	logic        rst_b;
	logic        rpin_b;
	logic        cs_b;
	logic        oe_b;
	logic        we_b;
	logic        din;
	logic        ms_b;
	logic        dout;
	logic        dout_oe;
	logic        q;
	logic        ms;
	logic        qe;
	logic        ms_all;
	logic        qe_all;
	logic [63:0] rd;
	logic [63:0] row_w [5];
	logic [63:0] row_e [5];
	int          bad_count = 0;
	int          checks = 0;
	int          cyc_n = 0;
	psr_rtc_core #(.TICK_CYCLES(4)) DUT (.clk_sys_i(clk_sys), .rst_b_i(rst_b),
		.chip_select_in_b_i(cs_b), .oe_b_i(oe_b), .we_b_i(we_b), .data_in_i(din),
		.reset_pin_b_i(rpin_b), .memory_select_out_b_o(ms_b), .data_out_o(dout),
		.data_out_oe_o(dout_oe));
	psr_host_model host (.clk_sys_i(clk_sys), .dout_i(dout), .dout_oe_i(dout_oe),
		.ms_b_i(ms_b), .cs_b_o(cs_b), .oe_b_o(oe_b), .we_b_o(we_b), .din_o(din));
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task end_sim;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cyc_n++;
		if (cyc_n == 40000)
		begin
			bad_count++;
			end_sim;
		end
	end
	task pulse;
		@(negedge clk_sys);
		rpin_b = 1'b0;
		repeat (2) @(negedge clk_sys);
		rpin_b = 1'b1;
	endtask
	initial
	begin
		rst_b = 1'b0;
		rpin_b = 1'b1;
		row_w[0] = 64'h9812_3125_2359_5900;
		row_e[0] = 64'h9812_3125_2359_5900;
		row_w[1] = 64'h0001_0121_b200_0099;
		row_e[1] = 64'h0001_0121_b200_0099;
		row_w[2] = 64'h9912_3107_2359_5999;
		row_e[2] = 64'h0001_0101_0000_0000;
		row_w[3] = 64'h2402_2806_b159_5999;
		row_e[3] = 64'h2402_2907_9200_0000;
		row_w[4] = 64'hffff_ffff_ffff_ffff;
		row_e[4] = `PSR_ZERO_MASK;
		repeat (10) @(negedge clk_sys);
		`CHK("ms_rst", 1'b1, ms_b)
		`CHK("qe_rst", 1'b0, dout_oe)
		rst_b = 1'b1;
		host.unlock(64, -1);
		host.xfer(1'b0, 64'h0, rd, ms_all, qe_all);
		`CHK("rst_regs", `PSR_RST_REGS, rd)
		`CHK("ms_held", 1'b1, ms_all)
		`CHK("q_driven", 1'b1, qe_all)
		for (int k = 0; k < 5; k++)
		begin
			host.unlock(64, -1);
			host.xfer(1'b1, row_w[k], rd, ms_all, qe_all);
			host.unlock(64, -1);
			host.xfer(1'b0, 64'h0, rd, ms_all, qe_all);
			`CHK("row", row_e[k][63:8], rd[63:8])
			if (row_e[k][8*`PSR_IDX_WDAY + `PSR_WD_HALT])
				`CHK("row_frac", row_e[k][7:0], rd[7:0])
		end
		host.cyc(1'b0, 1'b0, q, ms, qe);
		`CHK("pass_ms", 1'b0, ms)
		`CHK("pass_qe", 1'b0, qe)
		host.unlock(64, 10);
		host.cyc(1'b0, 1'b0, q, ms, qe);
		`CHK("bad_ms", 1'b0, ms)
		host.unlock(30, -1);
		host.unlock(64, -1);
		pulse;
		host.xfer(1'b0, 64'h0, rd, ms_all, qe_all);
		`CHK("ign_rd", row_e[4], rd)
		`CHK("ign_ms", 1'b1, ms_all)
		host.unlock(64, -1);
		host.xfer(1'b1, row_w[0], rd, ms_all, qe_all);
		host.unlock(64, -1);
		for (int i = 0; i < 20; i++)
			host.cyc(1'b1, 1'b1, q, ms, qe);
		pulse;
		host.cyc(1'b0, 1'b0, q, ms, qe);
		`CHK("abort_ms", 1'b0, ms)
		host.unlock(64, -1);
		host.xfer(1'b0, 64'h0, rd, ms_all, qe_all);
		`CHK("abort_rd", row_e[0], rd)
		end_sim;
	end
endmodule
